// ===== logic/gripper_gap_timer.sv
// down counter that reports when a programmed interval has elapsed
`timescale 1ns/100ps
`default_nettype none
module gripper_gap_timer
  import gripper_pkg::*;
#(
  parameter int unsigned COUNT = 1000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic restart,
  output logic      done
);
  localparam int unsigned W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // restart reloads, otherwise count to zero and stay
  always_comb begin
    cnt_next = cnt_reg;
    if (restart) begin
      cnt_next = W'(COUNT);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // reset loads the full count so the interval also covers power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= W'(COUNT);
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0);
endmodule
`default_nettype wire

// ===== logic/gripper_move_command_interface.sv
// gripper command interface: discrete inputs, process image over apb, jaw model
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module gripper_move_command_interface
  import gripper_pkg::*;
#(
  parameter int unsigned GAP_COUNT    = GAP_CYCLES,
  parameter int unsigned EXCH_COUNT   = EXCH_CYCLES,
  parameter int unsigned STROKE_COUNT = STROKE_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // discrete command inputs
  input  wire logic        open_command_input,
  input  wire logic        close_command_input,
  // indicators and outputs
  output logic             ready_led,
  output logic      [15:0] analog_level,
  output logic             image_update
);
  // state
  motion_e     state_reg, state_next;
  logic [15:0] jaw_reg, jaw_next;
  logic [15:0] jaw_start_reg, jaw_start_next;
  logic [15:0] jaw_target, ramp_span, ramp_step, ramp_pos;
  logic [31:0] stroke_reg, stroke_next;
  logic [15:0] command_bits_reg, command_bits_next;
  logic [7:0]  gripping_profile_select_reg, gripping_profile_select_next;
  logic [7:0]  recipe_select_reg, recipe_select_next;
  logic [15:0] learned_part_location_reg, learned_part_location_next;
  logic [7:0]  clamp_strength_reg, clamp_strength_next;
  logic [7:0]  location_window_reg, location_window_next;
  logic [15:0] state_flags_reg, state_flags_next;
  logic [15:0] diag_reg, diag_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [31:0] exch_reg, exch_next;
  logic        open_d_reg, close_d_reg;
  logic        upd_reg, upd_next;
  logic        gap_done, gap_restart, boot_done;
  logic        apb_wr, apb_rd, addr_ok;
  logic        cmd_legal;

  // low interval timer, restarted whenever either input is high
  gripper_gap_timer #(.COUNT(GAP_COUNT)) u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (gap_restart),
    .done    (gap_done)
  );

  // start-up delay before commands are accepted
  gripper_gap_timer #(.COUNT(READY_CYCLES)) u_boot (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (1'b0),
    .done    (boot_done)
  );

  assign gap_restart = open_command_input | close_command_input;
  assign apb_wr      = psel & penable & pwrite;
  // reads are fetched in the setup cycle so the word stands in the access cycle
  assign apb_rd      = psel & ~penable & ~pwrite;
  assign pready      = 1'b1;
  // one-hot or zero check on the written command word
  assign cmd_legal   = ((pwdata[15:0] & (pwdata[15:0] - 16'h0001)) == 16'h0000);

  // apb address decode
  always_comb begin
    unique case (paddr)
      ADDR_CMD, ADDR_PARAM, ADDR_TEACH, ADDR_STATE,
      ADDR_DIAG, ADDR_JAW, ADDR_ANALOG: addr_ok = 1'b1;
      default:                          addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // output image registers, written over apb
  always_comb begin
    command_bits_next            = command_bits_reg;
    gripping_profile_select_next = gripping_profile_select_reg;
    recipe_select_next           = recipe_select_reg;
    learned_part_location_next   = learned_part_location_reg;
    clamp_strength_next          = clamp_strength_reg;
    location_window_next         = location_window_reg;
    if (apb_wr && paddr == ADDR_CMD && cmd_legal) begin
      command_bits_next = pwdata[15:0];
    end
    // field order: profile, recipe, strength, window
    if (apb_wr && paddr == ADDR_PARAM) begin
      gripping_profile_select_next = pwdata[7:0];
      recipe_select_next           = pwdata[15:8];
      clamp_strength_next          = pwdata[23:16];
      location_window_next         = pwdata[31:24];
    end
    if (apb_wr && paddr == ADDR_TEACH) begin
      learned_part_location_next = pwdata[15:0];
    end
  end

  // exchange cycle timer; image_update pulses once per cycle
  always_comb begin
    exch_next = exch_reg + 32'h0000_0001;
    upd_next  = 1'b0;
    if (exch_reg >= 32'(EXCH_COUNT - 1)) begin
      exch_next = 32'h0000_0000;
      upd_next  = 1'b1;
    end
  end

  // ramp from where the jaw stood to the end its direction names,
  // so the analogue level never jumps when a stroke begins
  always_comb begin
    jaw_target = (state_reg == ST_OPENING) ? JAW_MAX : JAW_MIN;
    ramp_span  = (jaw_target >= jaw_start_reg) ? (jaw_target - jaw_start_reg)
                                               : (jaw_start_reg - jaw_target);
    ramp_step  = 16'((32'(ramp_span) * stroke_reg) / 32'(STROKE_COUNT));
    ramp_pos   = (jaw_target >= jaw_start_reg) ? (jaw_start_reg + ramp_step)
                                               : (jaw_start_reg - ramp_step);
  end

  // motion state machine
  always_comb begin
    state_next     = state_reg;
    jaw_next       = jaw_reg;
    jaw_start_next = jaw_start_reg;
    stroke_next    = stroke_reg;
    unique case (state_reg)
      ST_BOOT: begin
        if (boot_done) begin
          state_next = ST_REST;
        end
      end
      ST_REST: begin
        // the resting position is where the next stroke starts from
        jaw_start_next = jaw_reg;
        // fresh rising level after the quiet interval only
        if (open_command_input && !open_d_reg && !close_command_input && gap_done) begin
          state_next  = ST_OPENING;
          stroke_next = 32'h0000_0000;
        end else if (close_command_input && !close_d_reg && !open_command_input
                     && gap_done) begin
          state_next  = ST_CLOSING;
          stroke_next = 32'h0000_0000;
        end else if (command_bits_reg == CMD_MOVE_OUTER) begin
          state_next  = ST_OPENING;
          stroke_next = 32'h0000_0000;
        end else if (command_bits_reg == CMD_MOVE_INNER) begin
          state_next  = ST_CLOSING;
          stroke_next = 32'h0000_0000;
        end
        // both inputs high falls through to the apb move word; with no move word set, stay at rest
      end
      ST_OPENING, ST_CLOSING: begin
        // inputs are ignored until the stroke ends
        stroke_next = stroke_reg + 32'h0000_0001;
        if (stroke_reg >= 32'(STROKE_COUNT - 1)) begin
          state_next = ST_REST;
          jaw_next   = (state_reg == ST_OPENING) ? JAW_MAX : JAW_MIN;
        end else begin
          jaw_next = ramp_pos;
        end
      end
    endcase
  end

  // state flags and diagnosis
  always_comb begin
    state_flags_next = state_flags_reg;
    diag_next        = diag_reg;
    state_flags_next[FLAG_MOVING]   = (state_next == ST_OPENING) || (state_next == ST_CLOSING);
    state_flags_next[FLAG_AT_OUTER] = (state_next == ST_REST) && (jaw_next == JAW_MAX);
    state_flags_next[FLAG_AT_INNER] = (state_next == ST_REST) && (jaw_next == JAW_MIN);
    // handshake flag follows the data transfer bit
    state_flags_next[FLAG_HANDSHAKE] = (command_bits_reg == CMD_DATA_TRANSFER);
    if (state_reg == ST_REST && open_command_input && close_command_input) begin
      diag_next = DIAG_BOTH_INPUTS;
    end else if (apb_wr && paddr == ADDR_CMD && !cmd_legal) begin
      diag_next = DIAG_BAD_COMMAND;
    end else if (command_bits_reg == CMD_ERROR_RESET) begin
      diag_next = DIAG_NONE;
    end
    state_flags_next[FLAG_ERROR] = (diag_next != DIAG_NONE);
  end

  // read data mux; zero outside the access cycle of a read
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (apb_rd) begin
      unique case (paddr)
        ADDR_CMD:    prdata_next = {16'h0000, command_bits_reg};
        ADDR_PARAM:  prdata_next = {location_window_reg, clamp_strength_reg,
                                    recipe_select_reg, gripping_profile_select_reg};
        ADDR_TEACH:  prdata_next = {16'h0000, learned_part_location_reg};
        ADDR_STATE:  prdata_next = {16'h0000, state_flags_reg};
        ADDR_DIAG:   prdata_next = {16'h0000, diag_reg};
        ADDR_JAW:    prdata_next = {16'h0000, jaw_reg};
        ADDR_ANALOG: prdata_next = {16'h0000, jaw_reg};
        default:     prdata_next = 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_reg;

  // register all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                   <= ST_BOOT;
      jaw_reg                     <= JAW_RESET;
      jaw_start_reg               <= JAW_RESET;
      stroke_reg                  <= 32'h0000_0000;
      command_bits_reg            <= 16'h0000;
      gripping_profile_select_reg <= 8'h00;
      recipe_select_reg           <= 8'h00;
      learned_part_location_reg   <= 16'h0000;
      clamp_strength_reg          <= 8'h00;
      location_window_reg         <= 8'h00;
      state_flags_reg             <= 16'h0000;
      diag_reg                    <= DIAG_NONE;
      prdata_reg                  <= 32'h0000_0000;
      exch_reg                    <= 32'h0000_0000;
      upd_reg                     <= 1'b0;
      open_d_reg                  <= 1'b1; // held-over level at boot never counts as fresh
      close_d_reg                 <= 1'b1;
    end else begin
      state_reg                   <= state_next;
      jaw_reg                     <= jaw_next;
      jaw_start_reg               <= jaw_start_next;
      stroke_reg                  <= stroke_next;
      command_bits_reg            <= command_bits_next;
      gripping_profile_select_reg <= gripping_profile_select_next;
      recipe_select_reg           <= recipe_select_next;
      learned_part_location_reg   <= learned_part_location_next;
      clamp_strength_reg          <= clamp_strength_next;
      location_window_reg         <= location_window_next;
      state_flags_reg             <= state_flags_next;
      diag_reg                    <= diag_next;
      prdata_reg                  <= prdata_next;
      exch_reg                    <= exch_next;
      upd_reg                     <= upd_next;
      open_d_reg                  <= open_command_input;
      close_d_reg                 <= close_command_input;
    end
  end

  // jaw position as linear 0..10 v code
  assign analog_level = jaw_reg;
  assign ready_led    = (state_reg != ST_BOOT);
  assign image_update = upd_reg;
endmodule
`default_nettype wire

// ===== logic/gripper_pkg.sv
// shared constants for the gripper move command interface
package gripper_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned GAP_TIME_MS       = 10;
  localparam int unsigned GAP_CYCLES        = (GAP_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CYCLE_TIME_MS     = 5;
  localparam int unsigned EXCH_CYCLES       = (CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned STROKE_CYCLES     = 100000;
  localparam int unsigned READY_CYCLES      = 1000;
  // jaw position range
  localparam logic [15:0] JAW_MIN           = 16'h0000;
  localparam logic [15:0] JAW_MAX           = 16'h0fa0;
  localparam logic [15:0] JAW_RESET         = 16'h0000;
  // command bits encodings
  localparam logic [15:0] CMD_DATA_TRANSFER = 16'h0001;
  localparam logic [15:0] CMD_MOVE_OUTER    = 16'h0100;
  localparam logic [15:0] CMD_MOVE_INNER    = 16'h0200;
  localparam logic [15:0] CMD_ERROR_RESET   = 16'h8000;
  // state flag bit positions
  localparam int unsigned FLAG_MOVING       = 0;
  localparam int unsigned FLAG_AT_OUTER     = 8;
  localparam int unsigned FLAG_AT_INNER     = 9;
  localparam int unsigned FLAG_HANDSHAKE    = 12;
  localparam int unsigned FLAG_ERROR        = 13;
  // diagnosis codes
  localparam logic [15:0] DIAG_NONE         = 16'h0000;
  localparam logic [15:0] DIAG_BAD_COMMAND  = 16'h0001;
  localparam logic [15:0] DIAG_BOTH_INPUTS  = 16'h0002;
  // apb register byte addresses
  localparam logic [11:0] ADDR_CMD          = 12'h000;
  localparam logic [11:0] ADDR_PARAM        = 12'h004;
  localparam logic [11:0] ADDR_TEACH        = 12'h008;
  localparam logic [11:0] ADDR_STATE        = 12'h00c;
  localparam logic [11:0] ADDR_DIAG         = 12'h010;
  localparam logic [11:0] ADDR_JAW          = 12'h014;
  localparam logic [11:0] ADDR_ANALOG       = 12'h018;
  // motion states
  typedef enum logic [1:0] {ST_BOOT, ST_REST, ST_OPENING, ST_CLOSING} motion_e;
endpackage

// ===== verif/gripper_cmd_checker_props.sv
// port-level property checker for the gripper command interface
`timescale 1ns/100ps
`default_nettype none
module gripper_cmd_checker
  import gripper_pkg::*;
#(
  parameter int unsigned EXCH_COUNT = 10
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // discrete side
  input wire logic        open_command_input,
  input wire logic        close_command_input,
  input wire logic        ready_led,
  input wire logic [15:0] analog_level,
  input wire logic        image_update
);
  int unsigned up_cnt_reg, up_cnt_next, gap_cnt_reg, gap_cnt_next;
  // cycles since reset (saturating) and since the last image pulse
  always_comb begin
    up_cnt_next  = (up_cnt_reg < 2000) ? up_cnt_reg + 1 : up_cnt_reg;
    gap_cnt_next = image_update ? 0 : gap_cnt_reg + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt_reg  <= 0;
      gap_cnt_reg <= 0;
    end else begin
      up_cnt_reg  <= up_cnt_next;
      gap_cnt_reg <= gap_cnt_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  slverr_map_a: assert property (
    psel && penable |-> pslverr == (paddr[1:0] != 2'b00 || paddr > ADDR_ANALOG))
    else $error("pslverr wrong");
  rdata_idle_a: assert property (
    !(psel && penable && !pwrite) |-> prdata == 32'h0000_0000) else $error("prdata not idle");
  read_width_a: assert property (
    psel && penable && !pwrite && paddr == ADDR_STATE |-> prdata[31:16] == 16'h0000)
    else $error("state read too wide");
  ready_hold_a: assert property (ready_led |=> ready_led) else $error("ready dropped");
  ready_time_a: assert property (
    (up_cnt_reg < 990 |-> !ready_led) and (up_cnt_reg > 1010 |-> ready_led))
    else $error("ready at wrong time");
  jaw_range_a: assert property (analog_level <= JAW_MAX) else $error("jaw out of range");
  stroke_on_a: assert property (
    analog_level > $past(analog_level) |=> analog_level >= $past(analog_level))
    else $error("stroke reversed");
  pulse_one_a: assert property (image_update |=> !image_update) else $error("pulse long");
  pulse_gap_a: assert property (
    image_update && up_cnt_reg > 2 * EXCH_COUNT + 2 |-> gap_cnt_reg == EXCH_COUNT - 1)
    else $error("image period wrong");
endmodule
`default_nettype wire

// ===== verif/gripper_controller_model.sv
// behavioural controller driving the two discrete command levels
`timescale 1ns/100ps
`default_nettype none
module gripper_controller_model (
  // clock
  input  wire logic pclk,
  // command levels
  output logic      open_command_input,
  output logic      close_command_input
);
  // both levels low from power-up on
  initial begin
    open_command_input  = 1'b0;
    close_command_input = 1'b0;
  end
  // raise, hold, drop both, then stay quiet; a short gap is only ever asked on purpose
  task automatic drive(input bit o, input bit c, input int hold, input int gap);
    @(posedge pclk);
    open_command_input  <= o;
    close_command_input <= c;
    repeat (hold) @(posedge pclk);
    open_command_input  <= 1'b0;
    close_command_input <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the gripper command interface
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb
  import gripper_pkg::*;
();
  localparam int GAP = 20, EXCH = 10, STROKE = 16;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
  logic        pready, pslverr, err, ready_led, image_update, opn, cls;
  logic [15:0] analog_level;
  int          mismatches = 0, n_tests = 0, model_jaw = 0, model_diag = 0, pulses;
  logic [15:0] mv [2] = '{CMD_MOVE_OUTER, CMD_MOVE_INNER};
  always #5 pclk = ~pclk;
  gripper_move_command_interface #(.GAP_COUNT(GAP), .EXCH_COUNT(EXCH), .STROKE_COUNT(STROKE))
    i_gripper_move_command_interface (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .open_command_input(opn), .close_command_input(cls),
    .ready_led(ready_led), .analog_level(analog_level), .image_update(image_update));
  gripper_controller_model ctrl (.pclk(pclk), .open_command_input(opn),
    .close_command_input(cls));
  // one apb transfer; response and read data are taken at the edge that completes it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    err = pslverr;
    rd  = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("rdata", e, rd)
  endtask
  // reference: a stroke starts from rest only on one fresh level after the gap
  task automatic move(input bit o, input bit c, input int hold, input int gap, input bit f);
    ctrl.drive(o, c, hold, gap);
    if (o && c) model_diag = DIAG_BOTH_INPUTS;
    else if (f) model_jaw = o ? JAW_MAX : JAW_MIN;
    `CHK("analog", 16'(model_jaw), analog_level)
    rd_chk(ADDR_JAW, model_jaw);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog at 20000 cycles, well beyond the expected run of under 1400 cycles
  initial begin
    #200_000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h55f4));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("led", 1'b0, ready_led)
    for (int i = 0; i < 1100 && ready_led !== 1'b1; i++) @(posedge pclk);
    `CHK("led", 1'b1, ready_led)
    move(1, 0, 2, GAP + 2, 1);
    move(0, 1, 2, GAP + 2, 1);
    move(1, 0, STROKE + 4, 5, 1);
    move(0, 1, 2, GAP + 2, 0);
    move(1, 1, 4, GAP + 2, 0);
    rd_chk(ADDR_DIAG, model_diag);
    apb(1'b1, ADDR_CMD, {16'h0000, CMD_ERROR_RESET});
    apb(1'b1, ADDR_CMD, 32'h0000_0000);
    rd_chk(ADDR_DIAG, DIAG_NONE);
    apb(1'b1, ADDR_CMD, 32'h0000_0003);
    rd_chk(ADDR_DIAG, DIAG_BAD_COMMAND);
    apb(1'b1, ADDR_CMD, {16'h0000, CMD_DATA_TRANSFER});
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    `CHK("handshake", 1'b1, rd[FLAG_HANDSHAKE])
    apb(1'b1, ADDR_CMD, 32'h0000_0000);
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    `CHK("handshake", 1'b0, rd[FLAG_HANDSHAKE])
    foreach (mv[i]) begin
      // clear the move word at once: a held word would start the stroke again
      apb(1'b1, ADDR_CMD, {16'h0000, mv[i]});
      apb(1'b1, ADDR_CMD, 32'h0000_0000);
      repeat (STROKE + 4) @(posedge pclk);
      model_jaw = (i == 0) ? JAW_MAX : JAW_MIN;
      rd_chk(ADDR_JAW, model_jaw);
    end
    v = $urandom();
    apb(1'b1, ADDR_PARAM, v);
    rd_chk(ADDR_PARAM, v);
    v = $urandom();
    apb(1'b1, ADDR_TEACH, v);
    rd_chk(ADDR_TEACH, {16'h0000, v[15:0]});
    apb(1'b1, 12'h01c, 32'h0000_0000);
    `CHK("slverr", 1'b1, err)
    pulses = 0;
    repeat (10 * EXCH) begin
      @(posedge pclk);
      if (image_update === 1'b1) pulses++;
    end
    `CHK("pulses", 10, pulses)
    tally_and_finish();
  end
endmodule
bind gripper_move_command_interface gripper_cmd_checker #(.EXCH_COUNT(EXCH_COUNT)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .open_command_input(open_command_input), .close_command_input(close_command_input),
  .ready_led(ready_led), .analog_level(analog_level), .image_update(image_update));
`default_nettype wire
